// [logic/pfar_pkg.sv]
// constants and carriers of the power-fail auto-restart block
// assumes a 100 MHz clock and the processor's io instruction timing
package pfar_pkg;
   localparam int unsigned CLK_MHZ = 100;
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned GRACE_US = 1000;
   localparam int unsigned SETTLE_MS = 200;
   localparam int unsigned EXEC_NS = 4250;
   localparam int unsigned GRACE_CYC = GRACE_US * CLK_MHZ;
   localparam int unsigned SETTLE_CYC = SETTLE_MS * 1000 * CLK_MHZ;
   localparam int unsigned EXEC_CYC_I = EXEC_NS / CLK_PERIOD_NS;
   localparam logic [8:0] EXEC_CYC = EXEC_CYC_I[8:0];
   localparam logic [11:0] OP_SKIP_SUPPLY_LOW = 12'hC42;
   localparam logic [11:0] ADDR_PC_STORE = 12'h000;
   localparam logic [11:0] ADDR_RESUME = 12'h001;
   localparam logic [11:0] ADDR_ZERO = 12'h000;

   typedef enum logic [2:0] {ST_RUN, ST_GRACE, ST_HOLD, ST_SETTLE,
      ST_MANUAL} pfar_state_t;

   // io instruction as presented by the processor
   typedef struct packed {
      logic valid;
      logic [11:0] ir;
      logic slot2;
   } pfar_iot_t;
endpackage : pfar_pkg

// [logic/pfar_timer.sv]
// delay counter used for the grace and settling periods; wraps at done and fires again if run stays high
// assumes run is held high for the whole wait; dropping it restarts
`timescale 1ns/1ps
module pfar_timer
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic run,
   input wire logic [31:0] limit,
   output logic done
);
   typedef struct packed {
      logic [31:0] cnt;
      logic done;
   } pfar_tmr_t;

   pfar_tmr_t s_q;
   pfar_tmr_t s_d;

   always_comb
   begin
      s_d = s_q;
      s_d.done = 1'b0;
      if (!run)
      begin
         s_d.cnt = 32'h0;
      end
      else if (s_q.cnt == limit - 32'h1)
      begin
         s_d.done = 1'b1;
         s_d.cnt = 32'h0;
      end
      else
      begin
         s_d.cnt = s_q.cnt + 32'h1;
      end
   end

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign done = s_q.done;
endmodule : pfar_timer

// [logic/pfar_top.sv]
// power-fail detection, grace period, hold and automatic restart
// assumes supply_ok and all processor inputs are synchronous to mclk
`timescale 1ns/1ps
module pfar_top
#(
   parameter int unsigned GRACE_CYCLES = pfar_pkg::GRACE_CYC,
   parameter int unsigned SETTLE_CYCLES = pfar_pkg::SETTLE_CYC
)
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic supply_ok,
   input wire logic restart_sw,
   input wire logic manual_start,
   input wire pfar_pkg::pfar_iot_t iot,
   input wire logic intr_ack,
   output logic supply_low_q,
   output logic intr_req_q,
   output logic run_enable_q,
   output logic program_counter_clear_q,
   output logic memory_address_register_clear_q,
   output logic start_q,
   output logic general_clear_q,
   output logic skip_on_supply_low_q,
   output logic iot_done_q,
   output logic vec_valid_q,
   output logic [11:0] vec_store_addr_q,
   output logic [11:0] vec_resume_addr_q
);
   typedef struct packed {
      pfar_pkg::pfar_state_t st;
      logic flag;
      logic irq;
      logic run;
      logic pcclr;
      logic maclr;
      logic start;
      logic gclr;
      logic skip;
      logic busy;
      logic [8:0] exec;
      logic done;
      logic vec;
      logic [11:0] store;
      logic [11:0] resume;
   } pfar_core_t;

   pfar_core_t s_q;
   pfar_core_t s_d;
   logic grace_done;
   logic settle_done;

   function automatic logic is_skip_op(input pfar_pkg::pfar_iot_t i);
      is_skip_op = i.valid && (i.ir == pfar_pkg::OP_SKIP_SUPPLY_LOW);
   endfunction : is_skip_op

   pfar_timer u_grace
   (
      .mclk(mclk),
      .nrst(nrst),
      .run(s_q.st == pfar_pkg::ST_GRACE),
      .limit(GRACE_CYCLES),
      .done(grace_done)
   );

   pfar_timer u_settle
   (
      .mclk(mclk),
      .nrst(nrst),
      .run((s_q.st == pfar_pkg::ST_SETTLE) && supply_ok),
      .limit(SETTLE_CYCLES),
      .done(settle_done)
   );

   always_comb
   begin
      s_d = s_q;
      s_d.pcclr = 1'b0;
      s_d.maclr = 1'b0;
      s_d.start = 1'b0;
      s_d.gclr = 1'b0;
      s_d.skip = 1'b0;
      s_d.done = 1'b0;
      s_d.vec = 1'b0;
      if (!supply_ok)
      begin
         s_d.flag = 1'b1;
      end
      case (s_q.st)
         pfar_pkg::ST_RUN:
         begin
            if (!supply_ok)
            begin
               s_d.st = pfar_pkg::ST_GRACE;
            end
         end
         pfar_pkg::ST_GRACE:
         begin
            s_d.run = 1'b1;
            if (grace_done)
            begin
               s_d.run = 1'b0;
               s_d.st = pfar_pkg::ST_HOLD;
            end
         end
         pfar_pkg::ST_HOLD:
         begin
            s_d.run = 1'b0;
            if (supply_ok)
            begin
               s_d.flag = 1'b0;
               if (restart_sw)
               begin
                  s_d.pcclr = 1'b1;
                  s_d.st = pfar_pkg::ST_SETTLE;
               end
               else
               begin
                  s_d.st = pfar_pkg::ST_MANUAL;
               end
            end
         end
         pfar_pkg::ST_SETTLE:
         begin
            if (!supply_ok)
            begin
               s_d.st = pfar_pkg::ST_HOLD;
            end
            else if (settle_done)
            begin
               s_d.start = 1'b1;
               s_d.maclr = 1'b1;
               s_d.gclr = 1'b1;
               s_d.run = 1'b1;
               s_d.st = pfar_pkg::ST_RUN;
            end
         end
         pfar_pkg::ST_MANUAL:
         begin
            if (!supply_ok)
            begin
               s_d.st = pfar_pkg::ST_HOLD;
            end
            else if (manual_start)
            begin
               s_d.run = 1'b1;
               s_d.st = pfar_pkg::ST_RUN;
            end
         end
         default:
         begin
            s_d.st = pfar_pkg::ST_HOLD;
         end
      endcase
      s_d.irq = s_d.flag;
      // sense in the second event slot, finish after the io time
      if (is_skip_op(iot) && iot.slot2 && s_q.flag)
      begin
         s_d.skip = 1'b1;
      end
      // a word still standing while done shows is not a new instruction
      if (is_skip_op(iot) && !s_q.busy && !s_q.done)
      begin
         s_d.busy = 1'b1;
         s_d.exec = 9'h001;
      end
      else if (s_q.busy)
      begin
         if (s_q.exec == pfar_pkg::EXEC_CYC)
         begin
            s_d.busy = 1'b0;
            s_d.done = 1'b1;
         end
         else
         begin
            s_d.exec = s_q.exec + 9'h001;
         end
      end
      if (intr_ack)
      begin
         s_d.vec = 1'b1;
         s_d.store = pfar_pkg::ADDR_PC_STORE;
         s_d.resume = pfar_pkg::ADDR_RESUME;
      end
   end

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         s_q <= '{st: pfar_pkg::ST_RUN, run: 1'b1, default: '0};
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign supply_low_q = s_q.flag;
   assign intr_req_q = s_q.irq;
   assign run_enable_q = s_q.run;
   assign program_counter_clear_q = s_q.pcclr;
   assign memory_address_register_clear_q = s_q.maclr;
   assign start_q = s_q.start;
   assign general_clear_q = s_q.gclr;
   assign skip_on_supply_low_q = s_q.skip;
   assign iot_done_q = s_q.done;
   assign vec_valid_q = s_q.vec;
   assign vec_store_addr_q = s_q.store;
   assign vec_resume_addr_q = s_q.resume;

   sequence s_recover;
      (s_q.st == pfar_pkg::ST_HOLD) && supply_ok;
   endsequence

   sequence s_auto_recover;
      s_recover ##0 restart_sw;
   endsequence

   AST_FLAG_SET: assert property (@(posedge mclk) disable iff (!nrst)
      !supply_ok |=> supply_low_q)
      else $error("flag not set on supply drop");
   AST_IRQ: assert property (@(posedge mclk) disable iff (!nrst)
      $rose(supply_low_q) |-> intr_req_q ##1 (intr_req_q || supply_ok))
      else $error("interrupt request does not follow flag");
   AST_GRACE: assert property (@(posedge mclk) disable iff (!nrst)
      (s_q.st == pfar_pkg::ST_RUN && !supply_ok && run_enable_q)
      |=> run_enable_q [*2])
      else $error("logic stopped inside grace period");
   AST_HOLD: assert property (@(posedge mclk) disable iff (!nrst)
      (s_q.st == pfar_pkg::ST_HOLD && !supply_ok) |=> !run_enable_q)
      else $error("processor not held during bad supply");
   AST_CLEAR: assert property (@(posedge mclk) disable iff (!nrst)
      s_recover |=> !supply_low_q)
      else $error("flag not cleared on recovery");
   AST_SWITCH: assert property (@(posedge mclk) disable iff (!nrst)
      start_q |-> $past(s_q.st == pfar_pkg::ST_SETTLE, 1))
      else $error("start without settling sequence");
   AST_PCCLR: assert property (@(posedge mclk) disable iff (!nrst)
      s_auto_recover |=> program_counter_clear_q
      && s_q.st == pfar_pkg::ST_SETTLE)
      else $error("counter not cleared at recovery");
   AST_MACLR: assert property (@(posedge mclk) disable iff (!nrst)
      start_q |-> memory_address_register_clear_q && general_clear_q)
      else $error("start without address and general clear");
   AST_NOAUTO: assert property (@(posedge mclk) disable iff (!nrst)
      (s_recover ##0 !restart_sw) |=> !start_q [*3])
      else $error("start issued with switch off");
   AST_SKIP: assert property (@(posedge mclk) disable iff (!nrst)
      (is_skip_op(iot) && iot.slot2 && supply_low_q)
      |=> skip_on_supply_low_q)
      else $error("skip missing with flag set");
   AST_VEC: assert property (@(posedge mclk) disable iff (!nrst)
      intr_ack |=> vec_valid_q && vec_store_addr_q == 12'h000
      && vec_resume_addr_q == 12'h001)
      else $error("wrong interrupt vector");
   AST_REDROP: assert property (@(posedge mclk) disable iff (!nrst)
      (s_q.st == pfar_pkg::ST_SETTLE && !supply_ok)
      |=> supply_low_q && s_q.st == pfar_pkg::ST_HOLD && !start_q)
      else $error("settling not abandoned on drop");
endmodule : pfar_top

// [verification/pfar_supply_model.sv]
// model of the supply status line and the console restart switch
// assumes the bench commands it; each command lands on the next edge
`timescale 1ns/1ps
module pfar_supply_model
(
   input wire logic mclk,
   input wire logic bad_cmd,
   input wire logic sw_cmd,
   output logic supply_ok,
   output logic restart_sw
);
   always @(posedge mclk)
   begin
      supply_ok <= !bad_cmd;
      restart_sw <= sw_cmd;
   end
endmodule : pfar_supply_model

// [verification/test_pfar_top.sv]
// self-checking bench for the power-fail auto-restart block
// assumes short grace and settle counts set at the instance
`timescale 1ns/1ps
module test_pfar_top;
   localparam int GR = 20;
   localparam int ST = 50;
   localparam int W_PCCLR = 0;
   localparam int W_START = 1;
   localparam int W_DONE = 2;
   logic mclk = 1'h0;
   logic nrst = 1'h0;
   logic bad_cmd = 1'h0;
   logic sw_cmd = 1'h1;
   logic manual_start = 1'h0;
   logic intr_ack = 1'h0;
   pfar_pkg::pfar_iot_t iot = '0;
   logic supply_ok, restart_sw, flag, irq, run, pcclr, maclr, start;
   logic gclr, skip, done, vv;
   logic [11:0] vs, vr;
   int err_count = 0;
   int n_checks = 0;
   int n_start = 0;

   pfar_supply_model u_pfar_supply_model (.mclk(mclk), .bad_cmd(bad_cmd),
      .sw_cmd(sw_cmd), .supply_ok(supply_ok), .restart_sw(restart_sw));
   pfar_top #(.GRACE_CYCLES(GR), .SETTLE_CYCLES(ST)) u_pfar_top (
      .mclk(mclk), .nrst(nrst), .supply_ok(supply_ok),
      .restart_sw(restart_sw), .manual_start(manual_start), .iot(iot),
      .intr_ack(intr_ack), .supply_low_q(flag), .intr_req_q(irq),
      .run_enable_q(run), .program_counter_clear_q(pcclr),
      .memory_address_register_clear_q(maclr), .start_q(start),
      .general_clear_q(gclr), .skip_on_supply_low_q(skip),
      .iot_done_q(done), .vec_valid_q(vv), .vec_store_addr_q(vs),
      .vec_resume_addr_q(vr));

   initial
   begin
      forever #5 mclk = ~mclk;
   end

   always @(posedge mclk)
      if (start === 1'h1)
         n_start <= n_start + 1;

   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : cyc

   function automatic logic probe(input int sel);
      case (sel)
         W_PCCLR: probe = pcclr;
         W_START: probe = start;
         default: probe = done;
      endcase
   endfunction : probe

   task automatic wait_hi(input int sel, input int lim, output int n);
      n = 0;
      while (probe(sel) !== 1'h1 && n < lim)
      begin
         cyc(1);
         n++;
      end
   endtask : wait_hi

   task automatic set_supply(input logic bad);
      @(posedge mclk);
      bad_cmd <= bad;
   endtask : set_supply

   task automatic test_done;
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : test_done

   // full drop, grace, hold, recovery and automatic start
   task automatic s_restart;
      int n;
      set_supply(1'h1);
      cyc(3);
      chk(flag, 1'h1);
      chk(irq, 1'h1);
      cyc(GR - 4);
      chk(run, 1'h1);
      cyc(8);
      chk(run, 1'h0);
      set_supply(1'h0);
      wait_hi(W_PCCLR, 6, n);
      chk(pcclr, 1'h1);
      chk(flag, 1'h0);
      chk(irq, 1'h0);
      wait_hi(W_START, ST + 6, n);
      chk(n >= ST - 3, 1'h1);
      chk(start, 1'h1);
      chk({maclr, gclr}, 2'h3);
      cyc(2);
      chk(run, 1'h1);
   endtask : s_restart

   task automatic iot_run(input logic exp);
      int n;
      @(posedge mclk);
      iot <= '{1'h1, pfar_pkg::OP_SKIP_SUPPLY_LOW, 1'h0};
      @(posedge mclk);
      iot.slot2 <= 1'h1;
      @(posedge mclk);
      iot.slot2 <= 1'h0;
      #1;
      chk(skip, exp);
      wait_hi(W_DONE, 440, n);
      chk(n >= 415, 1'h1);
      @(posedge mclk);
      iot <= '0;
   endtask : iot_run

   // skip and vector while held, then a drop in mid-settle
   task automatic s_redrop;
      int n;
      int k;
      set_supply(1'h1);
      cyc(GR + 8);
      iot_run(1'h1);
      @(posedge mclk);
      intr_ack <= 1'h1;
      @(posedge mclk);
      intr_ack <= 1'h0;
      #1;
      chk(vv, 1'h1);
      chk(vs, 12'h000);
      chk(vr, 12'h001);
      set_supply(1'h0);
      wait_hi(W_PCCLR, 6, n);
      k = n_start;
      cyc(ST / 2);
      set_supply(1'h1);
      cyc(3);
      chk(flag, 1'h1);
      chk(run, 1'h0);
      cyc(ST);
      chk(n_start - k, 12'h000);
      set_supply(1'h0);
      wait_hi(W_START, ST + 8, n);
      chk(n >= ST - 3, 1'h1);
      chk(start, 1'h1);
   endtask : s_redrop

   task automatic s_manual;
      int k;
      @(posedge mclk);
      sw_cmd <= 1'h0;
      set_supply(1'h1);
      cyc(GR + 8);
      set_supply(1'h0);
      cyc(4);
      chk(flag, 1'h0);
      k = n_start;
      cyc(ST + 10);
      chk(n_start - k, 12'h000);
      chk(run, 1'h0);
      @(posedge mclk);
      manual_start <= 1'h1;
      @(posedge mclk);
      manual_start <= 1'h0;
      cyc(3);
      chk(run, 1'h1);
      @(posedge mclk);
      sw_cmd <= 1'h1;
   endtask : s_manual

   initial
   begin
      repeat (20) @(posedge mclk);
      nrst <= 1'h1;
      cyc(2);
      chk({run, flag, start}, 3'h4);
      s_restart();
      cyc(4);
      iot_run(1'h0);
      s_redrop();
      cyc(4);
      s_manual();
      test_done();
   end

   initial
   begin
      #100000;
      err_count++;
      test_done();
   end
endmodule : test_pfar_top
